/* verilog/fpt_cfg.svh */
`ifndef FPT_CFG_SVH
`define FPT_CFG_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define FPT_OFF_CTRL 8'h00
`define FPT_OFF_STAT 8'h04
`define FPT_OFF_FCNT 8'h08

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define FPT_CTRL_LEGACY_EN 0
`define FPT_CTRL_FORCE_INH 1
`define FPT_CTRL_RESET 2'h1
`define FPT_STAT_INH 0
`define FPT_STAT_MODE_LSB 1
`define FPT_STAT_JMP_LSB 4
`define FPT_STAT_PIN_LSB 9

// ------------------------------------------------------------
// forced opcodes and timing
// ------------------------------------------------------------
`define FPT_OPC_NOP 8'h00
`define FPT_OPC_RST 8'hFF
`define FPT_STRAP_SETTLE 3'h5

`endif

/* verilog/fpt_pkg.sv */
package fpt_pkg;

  // processor cycle kinds presented by the core
  typedef enum logic [2:0] {
    FPT_CYC_FETCH = 3'h0,
    FPT_CYC_MEMRD = 3'h1,
    FPT_CYC_MEMWR = 3'h2,
    FPT_CYC_IORD = 3'h3,
    FPT_CYC_IOWR = 3'h4
  } fpt_cyc_t;

  // board mode, one-hot
  typedef enum logic [3:0] {
    FPT_ST_STRAP = 4'h1,
    FPT_ST_NORMAL = 4'h2,
    FPT_ST_NOP = 4'h4,
    FPT_ST_RST = 4'h8
  } fpt_state_t;

endpackage

/* verilog/fpt_pin_sync.sv */
`timescale 1ns/1ps
module fpt_pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // a change counts only once stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg[i] <= INIT[i];
          s2_reg[i] <= INIT[i];
          s3_reg[i] <= INIT[i];
          out_reg[i] <= INIT[i];
        end else begin
          s1_reg[i] <= pin_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          if (s2_reg[i] == s3_reg[i]) begin
            out_reg[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate

  assign pin_out = out_reg;

endmodule

/* verilog/fpt_stat_dec.sv */
`timescale 1ns/1ps
module fpt_stat_dec
  import fpt_pkg::*;
(
  input wire logic cyc_valid,
  input wire fpt_cyc_t cyc_type,
  output logic [4:0] stat_vec
);

  // order: {m1, memr, wo, inp, out}
  function automatic logic [4:0] stat_of(input fpt_cyc_t t);
    case (t)
      FPT_CYC_FETCH: stat_of = 5'h1C;
      FPT_CYC_MEMRD: stat_of = 5'h0C;
      FPT_CYC_IORD: stat_of = 5'h06;
      FPT_CYC_IOWR: stat_of = 5'h01;
      // writes to memory show no read status
      default: stat_of = 5'h00;
    endcase
  endfunction

  assign stat_vec = cyc_valid ? stat_of(cyc_type) : 5'h00;

endmodule

/* verilog/fpt_panel_test.sv */
`timescale 1ns/1ps
`include "fpt_cfg.svh"
module fpt_panel_test
  import fpt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic header_inhibit_n,
  input wire logic undefined_bus_line_n,
  input wire logic legacy_switch_input_inhibit_n,
  input wire logic inhibit_source_jumper,
  input wire logic rom_enable_jumper,
  input wire logic test_enable_jumper,
  input wire logic reset_jump_jumper,
  input wire logic test_select_jumper_a,
  input wire logic test_select_jumper_b,
  input wire logic cpu_cyc_valid,
  input wire fpt_cyc_t cpu_cyc_type,
  input wire logic [7:0] bus_data_in,
  input wire logic [7:0] panel_data_in,
  output logic [7:0] cpu_data_out,
  output logic cpu_data_valid,
  output logic bus_data_accept,
  output logic data_input_inhibit,
  output logic opcode_forced,
  output logic stat_m1,
  output logic stat_memr,
  output logic stat_wo,
  output logic stat_inp,
  output logic stat_out
);

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [8:0] pins_raw;
  logic [8:0] pins_sync;
  logic hdr_inh;
  logic line21_inh;
  logic line53_inh;
  logic src_bus;
  logic [4:0] jumpers;

  assign pins_raw = {test_select_jumper_b, test_select_jumper_a, reset_jump_jumper,
                     test_enable_jumper, rom_enable_jumper, inhibit_source_jumper,
                     legacy_switch_input_inhibit_n, undefined_bus_line_n,
                     header_inhibit_n};

  // pins reach the logic four edges after they change
  fpt_pin_sync #(.W(9), .INIT(9'h007)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  assign hdr_inh = !pins_sync[0];
  assign line21_inh = !pins_sync[1];
  assign line53_inh = !pins_sync[2];
  assign src_bus = pins_sync[3];
  assign jumpers = pins_sync[8:4];

  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  logic [1:0] ctrl_reg;
  logic [15:0] fcnt_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  fpt_state_t st_reg;
  fpt_state_t st_next;
  logic [2:0] settle_reg;
  logic apb_setup;
  logic apb_wr;
  logic inhibit;

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `FPT_CTRL_RESET;
    end else if (apb_wr && paddr == `FPT_OFF_CTRL) begin
      ctrl_reg <= pwdata[1:0];
    end
  end

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `FPT_OFF_CTRL) || (a == `FPT_OFF_STAT) || (a == `FPT_OFF_FCNT);
  endfunction

  // read data is captured in setup, so access always ends in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (apb_setup) begin
      pslverr_reg <= !addr_ok(paddr);
      case (paddr)
        `FPT_OFF_CTRL: prdata_reg <= {30'h0, ctrl_reg};
        `FPT_OFF_STAT: prdata_reg <= {20'h0, pins_sync[2:0], jumpers, st_reg[3:1], inhibit};
        `FPT_OFF_FCNT: prdata_reg <= {16'h0, fcnt_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign pready = psel && penable;
  assign prdata = prdata_reg;
  assign pslverr = psel && penable && pslverr_reg;

  // ----------------------------------------------------------
  // inhibit selection
  // ----------------------------------------------------------
  // legacy gate lets software free a bus whose pin 53 is grounded
  // source jumper select
  // bus lines dropped at header setting
  always_comb begin
    if (src_bus) begin
      inhibit = line21_inh || (line53_inh && ctrl_reg[`FPT_CTRL_LEGACY_EN]);
    end else begin
      inhibit = hdr_inh;
    end
    inhibit = inhibit || ctrl_reg[`FPT_CTRL_FORCE_INH];
  end

  assign data_input_inhibit = inhibit;
  assign bus_data_accept = !inhibit;

  // ----------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------
  // straps are read only after the synchronisers settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 3'h0;
    end else if (settle_reg != `FPT_STRAP_SETTLE) begin
      settle_reg <= settle_reg + 3'h1;
    end
  end

  always_comb begin
    case (st_reg)
      FPT_ST_STRAP: begin
        if (settle_reg != `FPT_STRAP_SETTLE) begin
          st_next = FPT_ST_STRAP;
        end else if (jumpers == 5'h1F) begin
          st_next = FPT_ST_NOP;
        end else if (jumpers == 5'h1B) begin
          st_next = FPT_ST_RST;
        end else begin
          st_next = FPT_ST_NORMAL;
        end
      end
      FPT_ST_NORMAL: st_next = FPT_ST_NORMAL;
      FPT_ST_NOP: st_next = FPT_ST_NOP;
      FPT_ST_RST: st_next = FPT_ST_RST;
      default: st_next = FPT_ST_STRAP;
    endcase
  end

  // mode is fixed until the next reset; straps moved later are ignored
  // runs from reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= FPT_ST_STRAP;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------
  // data path to the processor
  // ----------------------------------------------------------
  logic is_fetch;
  logic is_read;
  logic force_now;
  logic [7:0] data_next;

  assign is_fetch = cpu_cyc_valid && cpu_cyc_type == FPT_CYC_FETCH;
  assign is_read = cpu_cyc_valid && (cpu_cyc_type == FPT_CYC_FETCH ||
                   cpu_cyc_type == FPT_CYC_MEMRD || cpu_cyc_type == FPT_CYC_IORD);
  assign force_now = is_fetch && (st_reg == FPT_ST_NOP || st_reg == FPT_ST_RST);

  // forced opcodes win over inhibit, so a test mode runs with a panel fitted
  // forced no-op
  always_comb begin
    if (force_now && st_reg == FPT_ST_NOP) begin
      data_next = `FPT_OPC_NOP;
    end else if (force_now) begin
      data_next = `FPT_OPC_RST;
    end else if (inhibit) begin
      data_next = panel_data_in;
    end else begin
      data_next = bus_data_in;
    end
  end

  // writes leave the data register alone, so stack writes pass untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_data_out <= 8'h00;
      cpu_data_valid <= 1'b0;
      opcode_forced <= 1'b0;
    end else begin
      cpu_data_valid <= is_read;
      opcode_forced <= force_now;
      if (is_read) begin
        cpu_data_out <= data_next;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_reg <= 16'h0000;
    end else if (force_now) begin
      fcnt_reg <= fcnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------
  // bus status lines
  // ----------------------------------------------------------
  logic [4:0] stat_vec;

  fpt_stat_dec u_dec (
    .cyc_valid(cpu_cyc_valid),
    .cyc_type(cpu_cyc_type),
    .stat_vec(stat_vec)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {stat_m1, stat_memr, stat_wo, stat_inp, stat_out} <= 5'h00;
    end else begin
      {stat_m1, stat_memr, stat_wo, stat_inp, stat_out} <= stat_vec;
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SRC_HEADER: assert property (!src_bus && !ctrl_reg[1] |-> inhibit == hdr_inh)
    else $error("header inhibit not followed");
  AST_SRC_LINE21: assert property (src_bus && line21_inh |-> inhibit)
    else $error("line 21 inhibit not followed");
  AST_PANEL_DATA: assert property (is_read && !force_now && inhibit |=>
    cpu_data_out == $past(panel_data_in))
    else $error("bus data taken while inhibited");
  AST_BUS_DATA: assert property (is_read && !force_now && !inhibit |=>
    cpu_data_out == $past(bus_data_in) && cpu_data_valid)
    else $error("bus data not taken");
  AST_LEGACY: assert property (src_bus && ctrl_reg[0] && line53_inh |-> data_input_inhibit)
    else $error("legacy inhibit ignored");
  AST_IGNORE_BUS: assert property (!src_bus && !hdr_inh && !ctrl_reg[1] |-> bus_data_accept)
    else $error("bus lines not ignored");
  AST_NOP_FORCE: assert property (st_reg == FPT_ST_NOP && is_fetch |=>
    cpu_data_out == 8'h00 && opcode_forced)
    else $error("nop not forced");
  AST_RST_FORCE: assert property (st_reg == FPT_ST_RST && is_fetch |=>
    cpu_data_out == 8'hFF && opcode_forced)
    else $error("restart not forced");
  AST_MODE_SEL: assert property (st_reg == FPT_ST_STRAP && settle_reg == `FPT_STRAP_SETTLE &&
    jumpers == 5'h1B |=> st_reg == FPT_ST_RST)
    else $error("restart mode not selected");
  AST_START: assert property ($rose(settle_reg == `FPT_STRAP_SETTLE) |=> st_reg != FPT_ST_STRAP ##1
    $stable(st_reg)[*3])
    else $error("mode did not start");
  AST_FETCH_STAT: assert property (is_fetch |=> stat_m1 && stat_memr && stat_wo &&
    !stat_inp && !stat_out)
    else $error("fetch status wrong");
  AST_OPER_STAT: assert property (cpu_cyc_valid && cpu_cyc_type == FPT_CYC_MEMRD |=>
    !stat_m1 && stat_memr && stat_wo)
    else $error("operand status wrong");
  AST_IO_STAT: assert property (cpu_cyc_valid && cpu_cyc_type == FPT_CYC_IOWR |=>
    stat_out && !stat_wo && !stat_memr && !stat_inp && !stat_m1)
    else $error("output status wrong");
  AST_INP_STAT: assert property (cpu_cyc_valid && cpu_cyc_type == FPT_CYC_IORD |=>
    stat_inp && stat_wo && !stat_memr && !stat_m1 && !stat_out)
    else $error("input status wrong");
  AST_WR_PASS: assert property (cpu_cyc_valid && cpu_cyc_type == FPT_CYC_MEMWR |=>
    !opcode_forced && !cpu_data_valid && $stable(cpu_data_out))
    else $error("stack write disturbed");
  AST_NOP_SEL: assert property (st_reg == FPT_ST_STRAP && settle_reg == `FPT_STRAP_SETTLE &&
    jumpers == 5'h1F |=> st_reg == FPT_ST_NOP)
    else $error("nop mode not selected");
  AST_MODE_HOLD: assert property (st_reg != FPT_ST_STRAP |=> $stable(st_reg))
    else $error("mode changed without reset");
  AST_NORMAL_FREE: assert property (st_reg == FPT_ST_NORMAL && is_fetch |=> !opcode_forced)
    else $error("fetch forced in normal mode");
  AST_FCNT_STEP: assert property (force_now |=> fcnt_reg == $past(fcnt_reg) + 16'h0001)
    else $error("forced fetch not counted");
  AST_DATA_VALID: assert property (is_read |=> cpu_data_valid)
    else $error("read data not presented");
  AST_IDLE_STAT: assert property (!cpu_cyc_valid |=> !stat_m1 && !stat_memr && !stat_wo &&
    !stat_inp && !stat_out)
    else $error("status shown without a cycle");
  AST_MEMWR_STAT: assert property (cpu_cyc_valid && cpu_cyc_type == FPT_CYC_MEMWR |=>
    !stat_m1 && !stat_memr && !stat_wo && !stat_inp && !stat_out)
    else $error("stack write shows read status");
  AST_RD_HOLD: assert property (cpu_cyc_valid && !is_read |=> $stable(cpu_data_out))
    else $error("data changed on a write cycle");

  // ----------------------------------------------------------
  // cover points
  // ----------------------------------------------------------
  COV_NOP: cover property (st_reg == FPT_ST_NOP && is_fetch ##1 opcode_forced);
  COV_RST_WR: cover property (st_reg == FPT_ST_RST && cpu_cyc_valid && cpu_cyc_type == FPT_CYC_MEMWR);
  COV_RST: cover property (st_reg == FPT_ST_RST && is_fetch ##1 cpu_cyc_valid [*2]);
  COV_INH: cover property (is_read && inhibit && src_bus);
  COV_APB: cover property (apb_wr && paddr == 8'h00);

endmodule

/* bench/fpt_far_side.sv */
`timescale 1ns/1ps
module fpt_far_side (
  input wire logic panel_req,
  input wire logic line21_req,
  input wire logic line53_gnd,
  output logic header_inhibit_n,
  output logic undefined_bus_line_n,
  output logic legacy_switch_input_inhibit_n,
  output logic [7:0] panel_data,
  output logic [7:0] bus_data
);
  // ----------------------------------------
  // front panel and bus boards
  // ----------------------------------------
  // panel inhibit header
  assign header_inhibit_n = !panel_req;
  assign undefined_bus_line_n = !line21_req;
  assign legacy_switch_input_inhibit_n = !line53_gnd;
  assign panel_data = 8'hA5;
  assign bus_data = 8'h3C;
endmodule

/* bench/front_panel_inhibit_and_test_modes_tb.sv */
`timescale 1ns/1ps
module front_panel_inhibit_and_test_modes_tb;
  import fpt_pkg::*;
  typedef struct packed {logic src; logic [2:0] req; fpt_cyc_t t; logic inh;} fpt_row_t;
  logic pclk, presetn, psel, penable, pwrite, l_src, vld, pr, l21, l53;
  logic [7:0] paddr, pd, bd, dout;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, hn, ln, gn, dvld, acc, inh, frc;
  logic m1, mr, wo, inp, outs, err;
  logic [4:0] jmp;
  fpt_cyc_t ct;
  int n_errors = 0;
  int check_count = 0;
  fpt_row_t rows[6] = '{'{0, 3'b001, FPT_CYC_FETCH, 1}, '{0, 3'b110, FPT_CYC_MEMRD, 0},
    '{1, 3'b001, FPT_CYC_IORD, 0}, '{1, 3'b010, FPT_CYC_FETCH, 1},
    '{1, 3'b100, FPT_CYC_IOWR, 1}, '{1, 3'b100, FPT_CYC_MEMWR, 1}};
  fpt_far_side far_u (.panel_req(pr), .line21_req(l21), .line53_gnd(l53),
    .header_inhibit_n(hn), .undefined_bus_line_n(ln), .legacy_switch_input_inhibit_n(gn),
    .panel_data(pd), .bus_data(bd));
  fpt_panel_test dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .header_inhibit_n(hn), .undefined_bus_line_n(ln),
    .legacy_switch_input_inhibit_n(gn), .inhibit_source_jumper(l_src),
    .rom_enable_jumper(jmp[0]), .test_enable_jumper(jmp[1]), .reset_jump_jumper(jmp[2]),
    .test_select_jumper_a(jmp[3]), .test_select_jumper_b(jmp[4]), .cpu_cyc_valid(vld),
    .cpu_cyc_type(ct), .bus_data_in(bd), .panel_data_in(pd), .cpu_data_out(dout),
    .cpu_data_valid(dvld), .bus_data_accept(acc), .data_input_inhibit(inh),
    .opcode_forced(frc), .stat_m1(m1), .stat_memr(mr), .stat_wo(wo), .stat_inp(inp),
    .stat_out(outs));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task automatic give_verdict();
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // bus and cycle drivers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic cyc(input fpt_cyc_t t);
    @(posedge pclk);
    vld <= 1;
    ct <= t;
    @(posedge pclk);
    vld <= 0;
    #1;
  endtask
  function automatic logic [4:0] exp_stat(input fpt_cyc_t t);
    case (t)
      FPT_CYC_FETCH: return 5'b11100;
      FPT_CYC_MEMRD: return 5'b01100;
      FPT_CYC_IORD: return 5'b00110;
      FPT_CYC_IOWR: return 5'b00001;
      default: return 5'b00000;
    endcase
  endfunction
  task automatic boot(input logic [4:0] j);
    @(posedge pclk);
    jmp <= j;
    presetn <= 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    repeat (16) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, vld, pr, l21, l53, l_src} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    jmp = 5'h00;
    ct = FPT_CYC_FETCH;
    boot(5'h00);
    foreach (rows[i]) begin
      @(posedge pclk);
      l_src <= rows[i].src;
      {l53, l21, pr} <= rows[i].req;
      repeat (6) @(posedge pclk);
      chk(inh, rows[i].inh);
      chk(acc, !rows[i].inh);
      cyc(rows[i].t);
      chk({m1, mr, wo, inp, outs}, exp_stat(rows[i].t));
      chk(frc, 0);
      if (exp_stat(rows[i].t) != 5'b00001 && exp_stat(rows[i].t) != 0) begin
        chk(dvld, 1);
        chk(dout, rows[i].inh ? pd : bd);
      end
    end
    // legacy line disabled from control, then forced inhibit
    apb(0, 8'h00, 0);
    chk(rd, 32'h1);
    apb(1, 8'h00, 32'h0);
    repeat (2) @(posedge pclk);
    chk(inh, 0);
    apb(1, 8'h00, 32'h2);
    @(posedge pclk);
    chk(inh, 1);
    apb(0, 8'h40, 0);
    chk(err, 1);
    chk(rd, 0);
    // no-operation mode, then restart mode
    {l53, l21, pr} <= 3'b000;
    boot(5'h1F);
    apb(0, 8'h04, 0);
    chk(rd[3:1], 3'b010);
    repeat (3) begin
      cyc(FPT_CYC_FETCH);
      chk(dout, 8'h00);
      chk(frc, 1);
    end
    apb(0, 8'h08, 0);
    chk(rd, 32'h3);
    boot(5'h1B);
    repeat (2) begin
      cyc(FPT_CYC_FETCH);
      chk(dout, 8'hFF);
      chk({m1, mr, wo}, 3'b111);
      cyc(FPT_CYC_MEMWR);
      chk(frc, 0);
      cyc(FPT_CYC_MEMWR);
      chk({m1, mr, wo, inp, outs}, 5'b00000);
    end
    give_verdict();
  end
endmodule
